// *** verilog/stl_cfg.svh ***
// Purpose: constants of the self-test log controller
// Assumes: 125 MHz mclk, AXI4-Lite register access
// Notes: Notes on behaviour follow
`ifndef STL_CFG_SVH
`define STL_CFG_SVH

`define STL_OFS_CTRL    8'h00
`define STL_OFS_STATUS  8'h04
`define STL_OFS_EXTDUR  8'h08
`define STL_OFS_LOGIDX  8'h0C
`define STL_OFS_LOGA    8'h10
`define STL_OFS_LOGB    8'h14
`define STL_OFS_ISTAT   8'h18
`define STL_OFS_IMASK   8'h1C

`define STL_FC_HI       7
`define STL_FC_LO       5
`define STL_FC_SHORT    3'h1
`define STL_FC_EXT      3'h2
`define STL_FC_ABORT    3'h4

`define STL_RES_PASS    4'h0
`define STL_RES_HOST    4'h1
`define STL_RES_RESET   4'h2
`define STL_RES_SEGBASE 4'h5
`define STL_RES_RUN     4'hF

`define STL_SEG_ELEC    2'h0
`define STL_SEG_SERVO   2'h1
`define STL_SEG_SCAN    2'h2

`define STL_IRQ_PASS    0
`define STL_IRQ_FAIL    1
`define STL_IRQ_ABORT   2

`define STL_LOG_DEPTH   20
`define STL_CLK_NS      8
`define STL_MS_NS       1000000
`define STL_TICK_CYC    (`STL_MS_NS / `STL_CLK_NS)
`define STL_SHORT_S     120
`define STL_SHORT_MS    (`STL_SHORT_S * 1000)
`define STL_EXT_MIN     16'h003C

`endif

// *** verilog/stl_pkg.sv ***
// Purpose: types of the self-test log controller
// Assumes: nothing beyond the constants header
// Notes: state codes are written out
package stl_pkg;
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_LAUNCH = 2'b01,
      ST_WAIT   = 2'b10,
      ST_FINISH = 2'b11
   } stl_state_type;
endpackage

// *** verilog/stl_self_test.sv ***
// Purpose: self-test sequencer and rolling result log behind AXI4-Lite
// Assumes: segment engine reports done/fail once per launched segment
// Notes: log held in flip-flops; NV copy written by outside store on nvReq
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "stl_cfg.svh"

module stl_self_test
   import stl_pkg::*;
#(
   parameter int          TICK_CYC  = `STL_TICK_CYC,
   parameter int          SHORT_MS  = `STL_SHORT_MS,
   parameter logic [15:0] EXT_MIN   = `STL_EXT_MIN,
   parameter int          LOG_DEPTH = `STL_LOG_DEPTH
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // axi4-lite write
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // segment engine
   output logic             segStart,
   output logic [1:0]       segId,
   output logic             segFullScan,
   output logic             segRwr,
   input  wire logic        segDone,
   input  wire logic        segFail,
   // failure details
   input  wire logic [3:0]  senseKey,
   input  wire logic [7:0]  asc,
   input  wire logic [7:0]  ascq,
   input  wire logic [7:0]  replaceableUnitCode,
   input  wire logic [31:0] failLba,
   input  wire logic        failLbaValid,
   // abort sources
   input  wire logic        busReset,
   input  wire logic        devResetMsg,
   // non-volatile log store
   output logic             nvReq,
   input  wire logic        nvAck,
   // interrupt
   output logic             irq
);
   localparam int IW = $clog2(LOG_DEPTH + 1);

   stl_state_type state_ff;
   logic          awGot_ff, wGot_ff, awready_ff, wready_ff, bvalid_ff;
   logic [1:0]    bresp_ff, rresp_ff;
   logic          arready_ff, rvalid_ff, segStart_ff, segFull_ff, segRwr_ff;
   logic          nvReq_ff, irq_ff;
   logic [7:0]    awAddr_ff;
   logic [31:0]   wData_ff, rdata_ff;
   logic [3:0]    wStrb_ff;
   logic [1:0]    seg_ff;
   logic [2:0]    fc_ff;
   logic [3:0]    finRes_ff;
   logic          finFail_ff;
   logic [2:0]    istat_ff, imask_ff;
   logic [IW-1:0] logCnt_ff, logIdx_ff;
   logic [31:0]   tickCnt_ff, msCnt_ff;
   logic          tick;
   logic          wrEn, ctrlWr, startReq, abortReq, resetAbort, timeUp;
   logic [2:0]    wFc;
   logic [2:0]    lgFc   [LOG_DEPTH];
   logic [3:0]    lgRes  [LOG_DEPTH];
   logic [3:0]    lgSk   [LOG_DEPTH];
   logic [7:0]    lgAsc  [LOG_DEPTH];
   logic [7:0]    lgAscq [LOG_DEPTH];
   logic [7:0]    lgUnit [LOG_DEPTH];
   logic [31:0]   lgLba  [LOG_DEPTH];
   logic          lgLbaV [LOG_DEPTH];

   function automatic logic mapped(input logic [7:0] a);
      return a[1:0] == 2'h0 && a <= `STL_OFS_IMASK;
   endfunction

   // register write decode
   assign wrEn     = awGot_ff && wGot_ff && !bvalid_ff;
   assign ctrlWr   = wrEn && awAddr_ff == `STL_OFS_CTRL && wStrb_ff[0];
   assign wFc      = wData_ff[`STL_FC_HI:`STL_FC_LO];
   assign startReq = ctrlWr && state_ff == ST_IDLE
                     && (wFc == `STL_FC_SHORT || wFc == `STL_FC_EXT);
   assign abortReq = ctrlWr && state_ff != ST_IDLE
                     && wFc == `STL_FC_ABORT;
   assign resetAbort = busReset || devResetMsg;
   assign timeUp   = fc_ff == `STL_FC_SHORT
                     && msCnt_ff >= 32'(SHORT_MS);
   assign tick     = tickCnt_ff == 32'(TICK_CYC - 1);

   // write address and data may arrive in either order
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         awGot_ff   <= 1'b0;
         awready_ff <= 1'b0;
         awAddr_ff  <= 8'h00;
      end else if (awvalid && awready_ff) begin
         awGot_ff   <= 1'b1;
         awready_ff <= 1'b0;
         awAddr_ff  <= awaddr;
      end else if (wrEn) begin
         awGot_ff   <= 1'b0;
      end else begin
         awready_ff <= !awGot_ff;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wGot_ff   <= 1'b0;
         wready_ff <= 1'b0;
         wData_ff  <= 32'h0000_0000;
         wStrb_ff  <= 4'h0;
      end else if (wvalid && wready_ff) begin
         wGot_ff   <= 1'b1;
         wready_ff <= 1'b0;
         wData_ff  <= wdata;
         wStrb_ff  <= wstrb;
      end else if (wrEn) begin
         wGot_ff   <= 1'b0;
      end else begin
         wready_ff <= !wGot_ff;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= 2'h0;
      end else if (wrEn) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= mapped(awAddr_ff) ? 2'h0 : 2'h2;
      end else if (bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // software registers; hardware set wins over write-one-to-clear
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         imask_ff  <= 3'h0;
         logIdx_ff <= '0;
         istat_ff  <= 3'h0;
      end else begin
         if (wrEn && awAddr_ff == `STL_OFS_IMASK && wStrb_ff[0])
            imask_ff <= wData_ff[2:0];
         if (wrEn && awAddr_ff == `STL_OFS_LOGIDX && wStrb_ff[0])
            logIdx_ff <= wData_ff[IW-1:0];
         if (wrEn && awAddr_ff == `STL_OFS_ISTAT && wStrb_ff[0])
            istat_ff <= istat_ff & ~wData_ff[2:0];
         if (state_ff == ST_FINISH && finRes_ff == `STL_RES_PASS)
            istat_ff[`STL_IRQ_PASS] <= 1'b1;
         else if (state_ff == ST_FINISH && finFail_ff)
            istat_ff[`STL_IRQ_FAIL] <= 1'b1;
         else if (state_ff == ST_FINISH)
            istat_ff[`STL_IRQ_ABORT] <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n)
         irq_ff <= 1'b0;
      else
         irq_ff <= |(istat_ff & imask_ff);
   end

   // read channel: one read in flight, data registered
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= 2'h0;
      end else if (arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rdata_ff   <= rdWord(araddr);
         rresp_ff   <= mapped(araddr) ? 2'h0 : 2'h2;
      end else if (rvalid_ff && rready) begin
         rvalid_ff  <= 1'b0;
      end else begin
         arready_ff <= !rvalid_ff;
      end
   end

   function automatic logic [31:0] rdWord(input logic [7:0] a);
      logic [31:0] v;
      logic        hit;
      v   = 32'h0000_0000;
      hit = logIdx_ff < logCnt_ff;
      case (a)
         `STL_OFS_STATUS:
            v = {16'h0000, finRes_ff, fc_ff, seg_ff,
                 3'(logCnt_ff), 1'b0, nvReq_ff, state_ff};
         `STL_OFS_EXTDUR: v = {16'h0000, EXT_MIN};
         `STL_OFS_LOGIDX: v = 32'(logIdx_ff);
         `STL_OFS_LOGA: if (hit)
            v = {lgUnit[logIdx_ff][3:0], lgAscq[logIdx_ff], lgAsc[logIdx_ff],
                 lgSk[logIdx_ff], lgLbaV[logIdx_ff], lgFc[logIdx_ff],
                 lgRes[logIdx_ff]};
         `STL_OFS_LOGB:  if (hit) v = lgLba[logIdx_ff];
         `STL_OFS_ISTAT: v = {29'h0, istat_ff};
         `STL_OFS_IMASK: v = {29'h0, imask_ff};
         default:        v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // millisecond divider and short test time budget
   always_ff @(posedge mclk) begin
      if (!rst_n || state_ff == ST_IDLE) begin
         tickCnt_ff <= 32'h0000_0000;
         msCnt_ff   <= 32'h0000_0000;
      end else begin
         tickCnt_ff <= tick ? 32'h0000_0000 : tickCnt_ff + 32'h1;
         if (tick)
            msCnt_ff <= msCnt_ff + 32'h1;
      end
   end

   // sequencer over the three segments
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_ff    <= ST_IDLE;
         seg_ff      <= `STL_SEG_ELEC;
         fc_ff       <= 3'h0;
         finRes_ff   <= `STL_RES_PASS;
         finFail_ff  <= 1'b0;
         segStart_ff <= 1'b0;
         segFull_ff  <= 1'b0;
         segRwr_ff   <= 1'b0;
      end else begin
         segStart_ff <= 1'b0;
         case (state_ff)
            ST_IDLE:
               if (startReq) begin
                  fc_ff      <= wFc;
                  seg_ff     <= `STL_SEG_ELEC;
                  finRes_ff  <= `STL_RES_RUN;
                  finFail_ff <= 1'b0;
                  segFull_ff <= wFc == `STL_FC_EXT;
                  segRwr_ff  <= wFc == `STL_FC_EXT;
                  state_ff   <= ST_LAUNCH;
               end
            ST_LAUNCH, ST_WAIT: begin
               if (resetAbort) begin
                  finRes_ff <= `STL_RES_RESET;
                  state_ff  <= ST_FINISH;
               end else if (abortReq) begin
                  finRes_ff <= `STL_RES_HOST;
                  state_ff  <= ST_FINISH;
               end else if (state_ff == ST_LAUNCH) begin
                  segStart_ff <= 1'b1;
                  state_ff    <= ST_WAIT;
               end else if (segDone && segFail) begin
                  // engine flags only unrecovered errors
                  finRes_ff  <= `STL_RES_SEGBASE + {2'h0, seg_ff};
                  finFail_ff <= 1'b1;
                  state_ff   <= ST_FINISH;
               end else if (timeUp) begin
                  // remaining segments are skipped, nothing failed so far
                  finRes_ff <= `STL_RES_PASS;
                  state_ff  <= ST_FINISH;
               end else if (segDone) begin
                  // recovered errors never reach this point as a fail
                  if (seg_ff == `STL_SEG_SCAN) begin
                     finRes_ff <= `STL_RES_PASS;
                     state_ff  <= ST_FINISH;
                  end else begin
                     seg_ff   <= seg_ff + 2'h1;
                     state_ff <= ST_LAUNCH;
                  end
               end
            end
            ST_FINISH: state_ff <= ST_IDLE;
            default:   state_ff <= ST_IDLE;
         endcase
      end
   end

   // result log: entry 0 is always the newest test
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         logCnt_ff <= '0;
         for (int i = 0; i < LOG_DEPTH; i++) begin
            lgFc[i]   <= 3'h0;
            lgRes[i]  <= 4'h0;
            lgSk[i]   <= 4'h0;
            lgAsc[i]  <= 8'h00;
            lgAscq[i] <= 8'h00;
            lgUnit[i] <= 8'h00;
            lgLba[i]  <= 32'h0000_0000;
            lgLbaV[i] <= 1'b0;
         end
      end else if (startReq) begin
         for (int i = LOG_DEPTH - 1; i > 0; i--) begin
            lgFc[i]   <= lgFc[i-1];
            lgRes[i]  <= lgRes[i-1];
            lgSk[i]   <= lgSk[i-1];
            lgAsc[i]  <= lgAsc[i-1];
            lgAscq[i] <= lgAscq[i-1];
            lgUnit[i] <= lgUnit[i-1];
            lgLba[i]  <= lgLba[i-1];
            lgLbaV[i] <= lgLbaV[i-1];
         end
         lgFc[0]   <= wFc;
         lgRes[0]  <= `STL_RES_RUN;
         lgSk[0]   <= 4'h0;
         lgAsc[0]  <= 8'h00;
         lgAscq[0] <= 8'h00;
         lgUnit[0] <= 8'h00;
         lgLba[0]  <= 32'h0000_0000;
         lgLbaV[0] <= 1'b0;
         if (logCnt_ff < IW'(LOG_DEPTH))
            logCnt_ff <= logCnt_ff + IW'(1);
      end else if (state_ff == ST_WAIT && segDone && segFail
                   && !resetAbort && !abortReq) begin
         lgSk[0]   <= senseKey;
         lgAsc[0]  <= asc;
         lgAscq[0] <= ascq;
         lgUnit[0] <= replaceableUnitCode;
         lgLba[0]  <= failLbaValid ? failLba : 32'h0000_0000;
         lgLbaV[0] <= failLbaValid;
      end else if (state_ff == ST_FINISH) begin
         lgRes[0] <= finRes_ff;
      end
   end

   // nv store request: new entry and final result each request a save
   always_ff @(posedge mclk) begin
      if (!rst_n)
         nvReq_ff <= 1'b0;
      else if (startReq || state_ff == ST_FINISH)
         nvReq_ff <= 1'b1;
      else if (nvAck)
         nvReq_ff <= 1'b0;
   end

   assign awready     = awready_ff;
   assign wready      = wready_ff;
   assign bvalid      = bvalid_ff;
   assign bresp       = bresp_ff;
   assign arready     = arready_ff;
   assign rvalid      = rvalid_ff;
   assign rdata       = rdata_ff;
   assign rresp       = rresp_ff;
   assign segStart    = segStart_ff;
   assign segId       = seg_ff;
   assign segFullScan = segFull_ff;
   assign segRwr      = segRwr_ff;
   assign nvReq       = nvReq_ff;
   assign irq         = irq_ff;
endmodule

`default_nettype wire

// *** test/stl_far_model.sv ***
// Purpose: segment engine and log store facing the controller
// Assumes: one segment in flight, segDone lat+2 cycles after segStart
// Notes: cancel drops a pending segment so stale results never land
`timescale 1ns/1ps
`default_nettype none
module stl_far_model (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // segment engine
   input  wire logic        segStart,
   input  wire logic [1:0]  segId,
   output logic             segDone,
   output logic             segFail,
   // scenario control
   input  wire logic [15:0] lat,
   input  wire logic [1:0]  failSeg,
   input  wire logic        cancel,
   // log store
   input  wire logic        nvReq,
   output logic             nvAck
);
   logic        busy_ff;
   logic [15:0] cnt_ff;
   logic [1:0]  id_ff;
   logic [1:0]  nvCnt_ff;
   logic        fin;

   assign fin = busy_ff && cnt_ff == 16'h0000;

   always_ff @(posedge mclk) begin
      if (!rst_n || cancel) begin
         busy_ff <= 1'b0;
         segDone <= 1'b0;
         segFail <= 1'b0;
      end else begin
         segDone <= fin;
         // fail flag toggles outside done so it is never trusted alone
         segFail <= fin ? id_ff == failSeg : !segFail;
         if (segStart) begin
            busy_ff <= 1'b1;
            cnt_ff <= lat;
            id_ff <= segId;
         end else if (busy_ff) begin
            busy_ff <= !fin;
            cnt_ff <= cnt_ff - 16'h0001;
         end
      end
   end

   // store answers three cycles after a request
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         nvCnt_ff <= 2'h0;
         nvAck <= 1'b0;
      end else begin
         nvAck <= nvReq && !nvAck && nvCnt_ff == 2'h2;
         nvCnt_ff <= (nvReq && !nvAck) ? nvCnt_ff + 2'h1 : 2'h0;
      end
   end
endmodule
`default_nettype wire

// *** test/stl_self_test_asserts.sv ***
// Purpose: port-level checks of the self-test controller
// Assumes: one clock, synchronous active-low reset
// Notes: log contents are judged by the bench, not here
`timescale 1ns/1ps
`default_nettype none
module stl_self_test_asserts (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // register bus answers
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   input  wire logic        bready,
   input  wire logic [31:0] rdata,
   input  wire logic        rvalid,
   input  wire logic        rready,
   // segment engine
   input  wire logic        segStart,
   input  wire logic [1:0]  segId,
   input  wire logic        segFullScan,
   input  wire logic        segRwr,
   input  wire logic        segDone,
   input  wire logic        segFail,
   // aborts and store
   input  wire logic        busReset,
   input  wire logic        devResetMsg,
   input  wire logic        nvReq,
   input  wire logic        nvAck
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence segPass;
      segDone && !segFail && segId != 2'h2 && !busReset && !devResetMsg;
   endsequence
   sequence segEnd;
      segDone && (segFail || segId == 2'h2) && !busReset && !devResetMsg;
   endsequence
   sequence rstHeld;
      (busReset || devResetMsg) [*3];
   endsequence

   a_start_pulse: assert property (segStart |=> !segStart)
      else $error("segment start longer than one cycle");
   a_seg_range: assert property (segStart |-> segId != 2'h3)
      else $error("unknown segment launched");
   a_seg_next: assert property (segPass |-> ##2 segStart)
      else $error("next segment not launched");
   a_scan_mode: assert property (segStart |-> segFullScan == segRwr)
      else $error("scan and write check modes disagree");
   a_nv_open: assert property (segStart && segId == 2'h0 |-> nvReq)
      else $error("new entry not stored at start");
   a_nv_hold: assert property (nvReq && !nvAck |=> nvReq)
      else $error("store request dropped before ack");
   a_nv_close: assert property (segEnd |-> ##2 nvReq)
      else $error("result not stored at finish");
   a_fail_stop: assert property (segDone && segFail |=> !segStart [*4])
      else $error("segment launched after a failure");
   a_reset_abort: assert property (rstHeld |-> !segStart)
      else $error("segment launched during bus reset");
   a_bresp_stand: assert property (
      bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response not held");
   a_rdata_stand: assert property (
      rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data not held");
endmodule
`default_nettype wire
bind stl_self_test stl_self_test_asserts stl_self_test_asserts_i (
   .mclk(mclk), .rst_n(rst_n), .bresp(bresp), .bvalid(bvalid),
   .bready(bready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
   .segStart(segStart), .segId(segId), .segFullScan(segFullScan),
   .segRwr(segRwr), .segDone(segDone), .segFail(segFail),
   .busReset(busReset), .devResetMsg(devResetMsg), .nvReq(nvReq),
   .nvAck(nvAck));

// *** test/tb.sv ***
// Purpose: self-checking bench of the self-test controller
// Assumes: short limit shrunk to 200 cycles by parameters
// Notes: the newest entry of a queue model of the log is compared after every test, the whole log at the end
`timescale 1ns/1ps
`default_nettype none
`include "stl_cfg.svh"
module tb;
   localparam int LIM = 4 * 50;
   logic        mclk = 1'b0, rst_n = 1'b0, cancel = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, asc = 8'h00, ascq = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, failLbaValid = 1'b0;
   logic [31:0] wdata = 32'h0, failLba = 32'h0, rdata;
   logic [1:0]  failSeg = 2'h3, bresp, rresp, segId;
   logic        busReset = 1'b0, devResetMsg = 1'b0;
   logic [3:0]  senseKey = 4'h0;
   logic [7:0]  unitCode = 8'h00;
   logic [15:0] lat = 16'h0028;
   logic        awready, wready, bvalid, arready, rvalid, nvReq, nvAck, irq;
   logic        segStart, segFullScan, segRwr, segDone, segFail;
   logic [31:0] mA[$], mB[$];
   int          errors = 0, checks_done = 0, cyc = 0;

   always #4 mclk = ~mclk;

   stl_self_test #(.TICK_CYC(4), .SHORT_MS(50)) stl_self_test_i (
      .mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .segStart(segStart),
      .segId(segId), .segFullScan(segFullScan), .segRwr(segRwr),
      .segDone(segDone), .segFail(segFail), .senseKey(senseKey), .asc(asc),
      .ascq(ascq), .replaceableUnitCode(unitCode), .failLba(failLba),
      .failLbaValid(failLbaValid), .busReset(busReset),
      .devResetMsg(devResetMsg), .nvReq(nvReq), .nvAck(nvAck), .irq(irq));
   stl_far_model stl_far_model_i (
      .mclk(mclk), .rst_n(rst_n), .segStart(segStart), .segId(segId),
      .segDone(segDone), .segFail(segFail), .lat(lat), .failSeg(failSeg),
      .cancel(cancel), .nvReq(nvReq), .nvAck(nvAck));

   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input logic [31:0] m);
      checks_done++;
      if ((got & m) !== (exp & m)) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
      bit done = 1'b0;
      @(posedge mclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            r = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
      bit done = 1'b0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task automatic rdlog(input int i, output logic [31:0] a,
                        output logic [31:0] b);
      logic [1:0] r;
      axw(`STL_OFS_LOGIDX, 32'(i), r);
      axr(`STL_OFS_LOGA, a, r);
      axr(`STL_OFS_LOGB, b, r);
   endtask

   task automatic run(input logic [2:0] fc, input int fs, input int ab);
      logic [31:0] a, b, s, m;
      logic [1:0]  r;
      logic [3:0]  res;
      bit          bad;
      bad = ab == 0 && fs < 3;
      failSeg <= 2'(fs);
      {senseKey, asc, ascq, unitCode} <= 28'($urandom);
      failLba <= $urandom;
      failLbaValid <= 1'($urandom);
      m = 32'($urandom_range(0, 7));
      axw(`STL_OFS_IMASK, m, r);
      axw(`STL_OFS_CTRL, {24'h0, fc, 5'h00}, r);
      chk({30'h0, r}, 32'h0, 32'h3);
      mA.push_front({25'h0, fc, `STL_RES_RUN});
      mB.push_front(32'h0);
      if (mA.size() > `STL_LOG_DEPTH) begin
         mA.pop_back();
         mB.pop_back();
      end
      rdlog(0, a, b);
      chk(a, mA[0], 32'hFFFFFFFF);
      chk({30'h0, segFullScan, segRwr},
          fc == `STL_FC_EXT ? 32'h3 : 32'h0, 32'h3);
      if (ab == 1) axw(`STL_OFS_CTRL, {24'h0, `STL_FC_ABORT, 5'h00}, r);
      if (ab > 1) begin
         @(posedge mclk);
         busReset <= ab == 2;
         devResetMsg <= ab == 3;
         repeat (3) @(posedge mclk);
         busReset <= 1'b0;
         devResetMsg <= 1'b0;
      end
      s = 32'h0;
      while (s[2:0] == 3'h0) axr(`STL_OFS_ISTAT, s, r);
      chk({31'h0, irq}, {31'h0, |(s[2:0] & m[2:0])}, 32'h1);
      cancel <= 1'b1;
      @(posedge mclk);
      cancel <= 1'b0;
      chk(s, ab > 0 ? 32'h4 : bad ? 32'h2 : 32'h1, 32'h7);
      res = ab == 1 ? `STL_RES_HOST : ab > 1 ? `STL_RES_RESET :
            bad ? `STL_RES_SEGBASE + 4'(fs) : `STL_RES_PASS;
      mA[0] = {25'h0, fc, res};
      if (bad) mA[0] = {unitCode[3:0], ascq, asc, senseKey, failLbaValid,
                        fc, res};
      if (bad && failLbaValid) mB[0] = failLba;
      axw(`STL_OFS_ISTAT, 32'h7, r);
      axr(`STL_OFS_ISTAT, s, r);
      chk({s[30:0], irq}, 32'h0, 32'hF);
      rdlog(0, a, b);
      chk(a, mA[0], 32'hFFFFFFFF);
      chk(b, mB[0], 32'hFFFFFFFF);
   endtask

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errors++;
         $display("[ERR] %0t run did not complete", $time);
         finish_test;
      end
   end

   initial begin
      logic [31:0] d, e;
      logic [1:0]  r;
      void'($urandom(32'h186A));
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      axr(`STL_OFS_EXTDUR, d, r);
      chk(d, {16'h0, `STL_EXT_MIN}, 32'hFFFFFFFF);
      axr(8'h20, d, r);
      chk({30'h0, r}, 32'h2, 32'h3);
      chk(d, 32'h0, 32'hFFFFFFFF);
      // i 5 outlives the short limit, so it ends early as a pass
      for (int i = 0; i < 22; i++) begin
         lat <= (i == 5) ? 16'(LIM + 50) : 16'h0028;
         run((i % 2 == 0 || i == 5) ? `STL_FC_SHORT : `STL_FC_EXT,
             (i % 3 == 1) ? (i / 3) % 3 : 3, (i >= 2 && i <= 4) ? i - 1 : 0);
      end
      for (int i = 0; i <= `STL_LOG_DEPTH; i++) begin
         rdlog(i, d, e);
         chk(d, i < mA.size() ? mA[i] : 32'h0,
             32'hFFFFFFFF);
         chk(e, i < mB.size() ? mB[i] : 32'h0,
             32'hFFFFFFFF);
      end
      finish_test;
   end
endmodule
`default_nettype wire
